// file: hw/nv_ctrl_pkg.sv
/*
 * Shared constants for the data EEPROM page-write control block.
 * Assumes a single 20 MHz system clock and synchronous active-high reset.
 */
package nv_ctrl_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int PROG_TIME_US = 4;
    localparam int PROG_CYCLES = (PROG_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
                                 PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam int READ_CYCLES = 4;
    localparam int TMR_DIV = 4;

    localparam logic [7:0] CTRL_BANK = 8'h01;
    localparam logic [7:0] CTRL_LOC = 8'h40;

    localparam int BIT_RD_START = 0;
    localparam int BIT_RD_EN = 1;
    localparam int BIT_WR_START = 2;
    localparam int BIT_WR_EN = 3;
    localparam int BIT_MODE = 4;
    localparam int BIT_ER_START = 5;
    localparam int BIT_ER_EN = 6;

    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PTR_HIGH_RESET = 8'h00;
    localparam logic [3:0] LOW_LAST = 4'hF;
    localparam int PAGE_BYTES = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_ERASE = 2'b10,
        ST_READ = 2'b11
    } nv_state_t;
endpackage : nv_ctrl_pkg

// file: hw/nv_prog_timer.sv
/*
 * Program-cycle timer: counts prescaled ticks and pulses done.
 * Assumes start is a one-cycle pulse; restarts are ignored while busy.
 */
`timescale 1ns/1ps
module nv_prog_timer (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic [15:0] length_in,
    output logic busy_out,
    output logic done_out
);
    import nv_ctrl_pkg::*;

    logic [7:0] div_reg;
    logic [15:0] cnt_reg;
    logic busy_reg;
    logic done_reg;
    wire tick = (div_reg == 8'(TMR_DIV - 1));

    // own prescaler stands in for the independent timer source
    always_ff @(posedge clk_in) begin
        if (srst_in || !busy_reg) begin
            div_reg <= 8'h00;
        end else begin
            div_reg <= tick ? 8'h00 : div_reg + 8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        done_reg <= 1'b0;
        if (srst_in) begin
            busy_reg <= 1'b0;
            cnt_reg <= 16'h0000;
        end else if (!busy_reg && start_in) begin
            busy_reg <= 1'b1;
            cnt_reg <= length_in;
        end else if (busy_reg && tick) begin
            if (cnt_reg <= 16'h0001) begin
                busy_reg <= 1'b0;
                done_reg <= 1'b1;
            end
            cnt_reg <= cnt_reg - 16'h0001;
        end
    end

    assign busy_out = busy_reg;
    assign done_out = done_reg;
endmodule : nv_prog_timer

// file: hw/nv_page_ctrl.sv
/*
 * Data EEPROM control: address/data registers, 16-byte page buffer,
 * indirectly reached control register, write/erase/read cycles, flags.
 * Assumes the CPU side presents one-cycle write strobes on clk_in.
 */
// Functional notes
// [RULE1] software erases the target page before page writing it
// [RULE2] mode bit high gives page writes of up to 16 bytes
// [RULE3] reset clears the page buffer
// [RULE4] write enable falling clears buffer; rising leaves it
// [RULE5] page mode increments low 4 address bits, upper 3 kept
// [RULE6] low nibble stops at 0FH; further data writes ignored
// [RULE7] data write copies byte into buffer then advances address
// [RULE8] software sets write enable then start in next instruction
// [RULE9] write start ignored unless write enable already set
// [RULE10] software masks global interrupts around start sequence
// [RULE11] independent timer times cycle; start bit self-clears at end
// [RULE12] write end clears write enable, emptying buffer
// [RULE13] reset clears write enable and pointer high bytes
// [RULE14] cycle end sets nv flag and multi-function flag
// [RULE15] vector only with all enables and stack not full
// [RULE16] service clears mf flag and global enable; sw clears nv flag
// [RULE17] software avoids sleep during a read or write
// [RULE18] control register reached only via pointer at bank 01H, 40H
// [RULE19] control bits: 6 er en, 5 er, 4 mode, 3 wr en, 2 wr, 1 rd en, 0 rd
// [RULE20] data written during erase only tags addresses
// [RULE21] software reloads address for each byte read
// [RULE22] read start self-clears; ignored without read enable
// [RULE23] erase end clears start then enable; page reads zero; code clears start and enable in the same cycle
// [RULE24] write and read start together invalid; register frozen while busy
`timescale 1ns/1ps
module nv_page_ctrl (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic addr_wr_in,
    input wire logic [6:0] addr_in,
    input wire logic data_wr_in,
    input wire logic [7:0] data_in,
    input wire logic ptr_high_wr_in,
    input wire logic ptr_sel_in,
    input wire logic [7:0] ptr_high_in,
    input wire logic ptr1_low_wr_in,
    input wire logic [7:0] ptr1_low_in,
    input wire logic ind_wr_in,
    input wire logic [7:0] ind_data_in,
    input wire logic nv_int_enable_in,
    input wire logic mf_int_enable_in,
    input wire logic global_int_set_in,
    input wire logic nv_flag_clear_in,
    input wire logic stack_full_in,
    input wire logic [15:0] prog_len_in,
    output logic [6:0] nv_address_out,
    output logic [7:0] nv_data_out,
    output logic [7:0] nv_control_out,
    output logic [7:0] ind_rd_data_out,
    output logic [7:0] pointer1_high_byte_out,
    output logic [7:0] pointer2_high_byte_out,
    output logic global_int_enable_out,
    output logic nv_int_flag_out,
    output logic mf_int_flag_out,
    output logic int_vector_out,
    output logic busy_out
);
    import nv_ctrl_pkg::*;

    logic [7:0] array_mem [0:127];
    logic [7:0] page_buf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] tag_reg;
    logic [6:0] nv_address_reg;
    logic [6:0] cyc_addr_reg;
    logic [7:0] nv_data_reg;
    logic [7:0] nv_control_reg;
    logic [7:0] ptr1_high_reg;
    logic [7:0] ptr2_high_reg;
    logic [7:0] ptr1_low_reg;
    logic global_int_enable_reg;
    logic nv_int_flag_reg;
    logic mf_int_flag_reg;
    logic page_full_reg;
    logic cyc_page_reg;
    nv_state_t state_reg;
    logic tmr_busy;
    logic tmr_done;

    // [RULE19] control bit map
    wire write_enable_bit = nv_control_reg[BIT_WR_EN];
    wire erase_enable_bit = nv_control_reg[BIT_ER_EN];
    wire read_enable_bit = nv_control_reg[BIT_RD_EN];
    wire mode_page = nv_control_reg[BIT_MODE];
    wire idle = (state_reg == ST_IDLE);

    // [RULE18] indirect decode only
    wire ptr_hits = (ptr1_high_reg == CTRL_BANK) && (ptr1_low_reg == CTRL_LOC);
    wire ctrl_wr = ind_wr_in && ptr_hits;
    // [RULE24] both starts together invalid
    wire both_start = ind_data_in[BIT_WR_START] && ind_data_in[BIT_RD_START];
    wire ctrl_accept = ctrl_wr && idle && !both_start;
    // [RULE9] start needs enable already set
    wire go_write = ctrl_accept && ind_data_in[BIT_WR_START] && write_enable_bit;
    wire go_erase = ctrl_accept && ind_data_in[BIT_ER_START] && erase_enable_bit && !go_write;
    // [RULE22] read needs enable already set
    wire go_read = ctrl_accept && ind_data_in[BIT_RD_START] && read_enable_bit && !go_write && !go_erase;
    // start bits enter only through the go terms, so a refused start reads 0
    wire [7:0] ctrl_written = ind_data_in & ~8'h25;
    // [RULE4] falling edge of either enable empties buffer
    wire wr_en_fall = write_enable_bit && ctrl_accept && !ind_data_in[BIT_WR_EN];
    wire er_en_fall = erase_enable_bit && ctrl_accept && !ind_data_in[BIT_ER_EN];
    wire cycle_end = tmr_done && (state_reg == ST_WRITE || state_reg == ST_ERASE);
    wire read_end = tmr_done && (state_reg == ST_READ);
    // [RULE12] write end drops enable, emptying buffer
    wire buf_clear = wr_en_fall || er_en_fall || cycle_end;
    // [RULE6] data ignored once page nibble stopped
    wire data_take = data_wr_in && idle && !(mode_page && page_full_reg);
    wire [3:0] slot = nv_address_reg[3:0];

    function automatic logic [6:0] step_addr(input logic [6:0] a);
        // [RULE5] upper page bits never carry
        step_addr = (a[3:0] == LOW_LAST) ? a : {a[6:4], a[3:0] + 4'h1};
    endfunction : step_addr

    // zero length falls back to the default program time
    nv_prog_timer nv_prog_timer_i (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(go_write || go_erase || go_read),
        .length_in(go_read ? 16'(READ_CYCLES) : (prog_len_in == 16'h0000 ? 16'(PROG_CYCLES) : prog_len_in)),
        .busy_out(tmr_busy),
        .done_out(tmr_done)
    );

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            cyc_page_reg <= 1'b0;
            cyc_addr_reg <= 7'h00;
        end else if (go_write) begin
            state_reg <= ST_WRITE;
            cyc_page_reg <= mode_page;
            cyc_addr_reg <= nv_address_reg;
        end else if (go_erase) begin
            state_reg <= ST_ERASE;
            cyc_page_reg <= mode_page;
            cyc_addr_reg <= nv_address_reg;
        end else if (go_read) begin
            state_reg <= ST_READ;
            cyc_page_reg <= mode_page;
            cyc_addr_reg <= nv_address_reg;
        end else if (tmr_done) begin
            // [RULE11] timer end returns to idle
            state_reg <= ST_IDLE;
        end
    end

    // [RULE13] reset closes write path
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nv_control_reg <= CTRL_RESET;
        end else if (ctrl_accept) begin
            nv_control_reg <= ctrl_written | {2'b00, go_erase, 2'b00, go_write, 1'b0, go_read};
        end else if (cycle_end && state_reg == ST_WRITE) begin
            // [RULE11] write start self-clears with enable
            nv_control_reg <= nv_control_reg & ~8'h0C;
        end else if (cycle_end) begin
            // [RULE23] erase start and enable drop
            nv_control_reg <= nv_control_reg & ~8'h60;
        end else if (read_end) begin
            nv_control_reg <= nv_control_reg & ~8'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            ptr1_high_reg <= PTR_HIGH_RESET;
            ptr2_high_reg <= PTR_HIGH_RESET;
            ptr1_low_reg <= 8'h00;
        end else begin
            if (ptr_high_wr_in && !ptr_sel_in) ptr1_high_reg <= ptr_high_in;
            if (ptr_high_wr_in && ptr_sel_in) ptr2_high_reg <= ptr_high_in;
            if (ptr1_low_wr_in) ptr1_low_reg <= ptr1_low_in;
        end
    end

    // [RULE7] buffer byte at current slot, then step
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nv_address_reg <= 7'h00;
            page_full_reg <= 1'b0;
        end else if (addr_wr_in && idle) begin
            nv_address_reg <= addr_in;
            page_full_reg <= 1'b0;
        end else if (data_take && mode_page) begin
            nv_address_reg <= step_addr(nv_address_reg);
            page_full_reg <= (slot == LOW_LAST);
        end else if (read_end && cyc_page_reg) begin
            nv_address_reg <= step_addr(nv_address_reg);
        end
    end

    // [RULE3] reset empties buffer
    always_ff @(posedge clk_in) begin
        if (srst_in || buf_clear) begin
            tag_reg <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) page_buf[i] <= 8'h00;
        end else if (data_take && mode_page) begin
            // [RULE20] erase only needs the tag
            tag_reg[slot] <= 1'b1;
            page_buf[slot] <= data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            nv_data_reg <= 8'h00;
        end else if (data_take) begin
            nv_data_reg <= data_in;
        end else if (read_end) begin
            nv_data_reg <= array_mem[cyc_addr_reg];
        end
    end

    // [RULE2] page commit writes tagged slots of 16
    always_ff @(posedge clk_in) begin
        if (cycle_end) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (!cyc_page_reg && i == 0) begin
                    array_mem[cyc_addr_reg] <= (state_reg == ST_WRITE) ? nv_data_reg : 8'h00;
                end else if (cyc_page_reg && tag_reg[i]) begin
                    // [RULE23] erased bytes read zero
                    array_mem[{cyc_addr_reg[6:4], 4'(i)}] <= (state_reg == ST_WRITE) ? page_buf[i] : 8'h00;
                end
            end
        end
    end

    wire vector = global_int_enable_reg && nv_int_enable_in && mf_int_enable_in && mf_int_flag_reg && !stack_full_in;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            global_int_enable_reg <= 1'b0;
            nv_int_flag_reg <= 1'b0;
            mf_int_flag_reg <= 1'b0;
        end else begin
            // [RULE14] set wins over clear
            nv_int_flag_reg <= cycle_end || (nv_int_flag_reg && !nv_flag_clear_in);
            // [RULE16] service clears mf flag and global enable
            mf_int_flag_reg <= cycle_end || (mf_int_flag_reg && !vector);
            global_int_enable_reg <= global_int_set_in || (global_int_enable_reg && !vector);
        end
    end

    // [RULE15] all enables and stack room
    assign int_vector_out = vector;
    assign nv_address_out = nv_address_reg;
    assign nv_data_out = nv_data_reg;
    assign nv_control_out = nv_control_reg;
    assign ind_rd_data_out = ptr_hits ? nv_control_reg : 8'h00;
    assign pointer1_high_byte_out = ptr1_high_reg;
    assign pointer2_high_byte_out = ptr2_high_reg;
    assign global_int_enable_out = global_int_enable_reg;
    assign nv_int_flag_out = nv_int_flag_reg;
    assign mf_int_flag_out = mf_int_flag_reg;
    assign busy_out = !idle || tmr_busy;

    // checks look one cycle after the event, once the registers have settled
    chk_start_needs_enable: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE9]
        (ctrl_wr && idle && ind_data_in[BIT_WR_START] && !write_enable_bit) |=> state_reg != ST_WRITE)
        else $error("write started without enable");

    chk_nibble_holds: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE6]
        (data_take && mode_page && slot == LOW_LAST) |=> nv_address_reg[3:0] == LOW_LAST)
        else $error("address nibble wrapped");

    chk_upper_kept: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE5]
        (data_take && mode_page && !addr_wr_in) |=> nv_address_reg[6:4] == $past(nv_address_reg[6:4]))
        else $error("page bits changed");

    chk_write_end_clr: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE12]
        (cycle_end && state_reg == ST_WRITE)
        |=> !nv_control_reg[BIT_WR_EN] && !nv_control_reg[BIT_WR_START] && tag_reg == '0)
        else $error("write end left enable set");

    chk_flags_on_end: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE14]
        cycle_end |=> nv_int_flag_reg && mf_int_flag_reg)
        else $error("flags not raised at cycle end");

    chk_vector_clears: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE16]
        (vector && !cycle_end && !global_int_set_in) |=> !mf_int_flag_reg && !global_int_enable_reg)
        else $error("service did not clear");

    chk_busy_frozen: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE24]
        (!idle && !tmr_done) |=> $stable(nv_control_reg))
        else $error("control changed while busy");

    chk_fall_clears: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE4]
        wr_en_fall |=> tag_reg == '0)
        else $error("buffer kept after enable fall");

    chk_read_needs_en: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE22]
        (ctrl_wr && idle && !read_enable_bit && !ind_data_in[BIT_WR_START] && !ind_data_in[BIT_ER_START])
        |=> state_reg != ST_READ)
        else $error("read started without enable");

    chk_start_runs_timer: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE11]
        go_write |=> state_reg == ST_WRITE && tmr_busy)
        else $error("write start did not launch the timer");

    chk_erase_end_clr: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE23]
        (cycle_end && state_reg == ST_ERASE) |=> !nv_control_reg[BIT_ER_START] && !nv_control_reg[BIT_ER_EN])
        else $error("erase end left start or enable set");

    chk_read_end_clr: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE22]
        read_end |=> !nv_control_reg[BIT_RD_START] && idle)
        else $error("read start not cleared at read end");

    chk_ctrl_via_ptr: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE18]
        (!ctrl_wr && !tmr_done) |=> $stable(nv_control_reg))
        else $error("control changed without a pointer hit");

    chk_both_refused: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE24]
        (ctrl_wr && idle && both_start) |=> $stable(nv_control_reg))
        else $error("write and read start together accepted");

    chk_reset_buffer: assert property (@(posedge clk_in) // [RULE3]
        srst_in |=> tag_reg == '0 && page_buf[0] == 8'h00)
        else $error("reset left the page buffer filled");

    chk_reset_closes: assert property (@(posedge clk_in) // [RULE13]
        srst_in |=> nv_control_reg == CTRL_RESET
            && ptr1_high_reg == PTR_HIGH_RESET && ptr2_high_reg == PTR_HIGH_RESET)
        else $error("reset left write path open");

    chk_byte_taken: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE7]
        (data_take && mode_page && !buf_clear) |=> tag_reg[$past(slot)] && nv_data_reg == $past(data_in))
        else $error("data byte not loaded into the page buffer");

    chk_rise_keeps: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE4]
        (ctrl_accept && !write_enable_bit && ind_data_in[BIT_WR_EN] && !er_en_fall && !data_take)
        |=> tag_reg == $past(tag_reg))
        else $error("buffer changed on enable rise");

    chk_full_drops: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE6]
        (data_wr_in && idle && mode_page && page_full_reg && !addr_wr_in)
        |=> $stable(nv_data_reg) && $stable(nv_address_reg))
        else $error("data write taken after page end");

    chk_nv_flag_kept: assert property (@(posedge clk_in) disable iff (srst_in) // [RULE16]
        (nv_int_flag_reg && !nv_flag_clear_in) |=> nv_int_flag_reg)
        else $error("nv flag cleared without software");
endmodule : nv_page_ctrl

// file: bench/eeprom_page_write_control_test.sv
/*
 * Self-checking bench for the data EEPROM page-write control block.
 * Drives every CPU-side strobe and level itself; assumes a 20 MHz clock
 * and a synchronous active-high reset, with a short program length.
 */
`timescale 1ns/1ps
module eeprom_page_write_control_test;
    import nv_ctrl_pkg::*;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic addr_wr_in = 1'b0;
    logic [6:0] addr_in = 7'h00;
    logic data_wr_in = 1'b0;
    logic [7:0] data_in = 8'h00;
    logic ptr_high_wr_in = 1'b0;
    logic ptr_sel_in = 1'b0;
    logic [7:0] ptr_high_in = 8'h00;
    logic ptr1_low_wr_in = 1'b0;
    logic [7:0] ptr1_low_in = 8'h00;
    logic ind_wr_in = 1'b0;
    logic [7:0] ind_data_in = 8'h00;
    logic nv_int_enable_in = 1'b0;
    logic mf_int_enable_in = 1'b0;
    logic global_int_set_in = 1'b0;
    logic nv_flag_clear_in = 1'b0;
    logic stack_full_in = 1'b0;
    // short program time keeps the run brief
    logic [15:0] prog_len_in = 16'h0002;
    logic [6:0] nv_address_out;
    logic [7:0] nv_data_out, nv_control_out, ind_rd_data_out;
    logic [7:0] pointer1_high_byte_out, pointer2_high_byte_out;
    logic global_int_enable_out, nv_int_flag_out, mf_int_flag_out, int_vector_out, busy_out;
    int err_count = 0;
    int n_checks = 0;
    int cycles = 0;
    int vec_seen = 0;

    nv_page_ctrl nv_page_ctrl_i (.clk_in(clk_in), .srst_in(srst_in), .addr_wr_in(addr_wr_in), .addr_in(addr_in),
        .data_wr_in(data_wr_in), .data_in(data_in), .ptr_high_wr_in(ptr_high_wr_in), .ptr_sel_in(ptr_sel_in),
        .ptr_high_in(ptr_high_in), .ptr1_low_wr_in(ptr1_low_wr_in), .ptr1_low_in(ptr1_low_in),
        .ind_wr_in(ind_wr_in), .ind_data_in(ind_data_in), .nv_int_enable_in(nv_int_enable_in),
        .mf_int_enable_in(mf_int_enable_in), .global_int_set_in(global_int_set_in),
        .nv_flag_clear_in(nv_flag_clear_in), .stack_full_in(stack_full_in), .prog_len_in(prog_len_in),
        .nv_address_out(nv_address_out), .nv_data_out(nv_data_out), .nv_control_out(nv_control_out),
        .ind_rd_data_out(ind_rd_data_out), .pointer1_high_byte_out(pointer1_high_byte_out),
        .pointer2_high_byte_out(pointer2_high_byte_out), .global_int_enable_out(global_int_enable_out),
        .nv_int_flag_out(nv_int_flag_out), .mf_int_flag_out(mf_int_flag_out),
        .int_vector_out(int_vector_out), .busy_out(busy_out));

    always #25 clk_in = ~clk_in;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // ceiling well above the roughly 150 cycles the tests need
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (int_vector_out === 1'b1) begin
            vec_seen <= vec_seen + 1;
        end
        if (cycles == 5000) begin
            err_count = err_count + 1;
            end_of_test();
        end
    end

    // one-cycle strobe: 0 addr, 1 data, 2 indirect, 3/4 pointer1/2 high, 5 pointer1 low, 6 gie set, 7 flag clr
    task automatic drv(input int k, input logic [7:0] v);
        @(posedge clk_in);
        addr_wr_in <= (k == 0);
        data_wr_in <= (k == 1);
        ind_wr_in <= (k == 2);
        ptr_high_wr_in <= (k == 3 || k == 4);
        ptr_sel_in <= (k == 4);
        ptr1_low_wr_in <= (k == 5);
        global_int_set_in <= (k == 6);
        nv_flag_clear_in <= (k == 7);
        addr_in <= v[6:0];
        data_in <= v;
        ind_data_in <= v;
        ptr_high_in <= v;
        ptr1_low_in <= v;
    endtask : drv

    task automatic put(input int k, input logic [7:0] v);
        drv(k, v);
        drv(8, 8'h00);
        @(negedge clk_in);
    endtask : put

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chk1

    task automatic wait_idle;
        int i;
        i = 0;
        while (busy_out !== 1'b0 && i < 300) begin
            @(negedge clk_in);
            i++;
        end
        chk1(busy_out, 1'b0);
    endtask : wait_idle

    initial begin
        repeat (16) @(posedge clk_in);
        srst_in <= 1'b0;
        @(negedge clk_in);
        chk(nv_control_out, CTRL_RESET);
        chk(pointer1_high_byte_out, PTR_HIGH_RESET);
        chk(pointer2_high_byte_out, PTR_HIGH_RESET);
        chk1(nv_int_flag_out, 1'b0);
        $display("test reset done");
        put(2, 8'h18);
        chk(nv_control_out, 8'h00);
        put(3, CTRL_BANK);
        put(5, 8'h41);
        put(2, 8'h18);
        chk(nv_control_out, 8'h00);
        put(5, CTRL_LOC);
        put(4, 8'h01);
        chk(pointer2_high_byte_out, 8'h01);
        chk(pointer1_high_byte_out, 8'h01);
        put(2, 8'h14);
        chk(nv_control_out, 8'h10);
        chk(ind_rd_data_out, 8'h10);
        $display("test pointer decode done");
        // erase the top four slots of page 3 before the page is written
        put(0, 8'h3C);
        repeat (4) put(1, 8'hFF);
        drv(2, 8'h50);
        put(2, 8'h70);
        chk(nv_control_out, 8'h70);
        wait_idle();
        chk(nv_control_out, 8'h10);
        chk1(nv_int_flag_out, 1'b1);
        $display("test page erase done");
        // page 3 loaded three slots before its end, so a fourth byte must be dropped
        put(0, 8'h3D);
        chk({1'b0, nv_address_out}, 8'h3D);
        put(1, 8'hA5);
        chk({1'b0, nv_address_out}, 8'h3E);
        chk(nv_data_out, 8'hA5);
        put(1, 8'h5A);
        chk({1'b0, nv_address_out}, 8'h3F);
        put(1, 8'hC3);
        chk({1'b0, nv_address_out}, 8'h3F);
        put(1, 8'h99);
        chk(nv_data_out, 8'hC3);
        drv(2, 8'h18);
        put(2, 8'h1C);
        chk(nv_control_out, 8'h1C);
        chk1(busy_out, 1'b1);
        put(6, 8'h00);
        put(2, 8'h00);
        chk(nv_control_out, 8'h1C);
        wait_idle();
        chk(nv_control_out, 8'h10);
        chk1(nv_int_flag_out, 1'b1);
        chk1(mf_int_flag_out, 1'b1);
        $display("test page write done");
        @(posedge clk_in);
        stack_full_in <= 1'b1;
        nv_int_enable_in <= 1'b1;
        mf_int_enable_in <= 1'b1;
        put(6, 8'h00);
        put(8, 8'h00);
        chk1(global_int_enable_out, 1'b1);
        chk1(mf_int_flag_out, 1'b1);
        chk1(vec_seen == 0, 1'b1);
        @(posedge clk_in);
        stack_full_in <= 1'b0;
        put(8, 8'h00);
        put(8, 8'h00);
        chk1(vec_seen == 1, 1'b1);
        chk1(mf_int_flag_out, 1'b0);
        chk1(global_int_enable_out, 1'b0);
        chk1(nv_int_flag_out, 1'b1);
        put(7, 8'h00);
        chk1(nv_int_flag_out, 1'b0);
        @(posedge clk_in);
        nv_int_enable_in <= 1'b0;
        $display("test interrupt done");
        put(2, 8'h18);
        put(2, 8'h1D);
        chk(nv_control_out, 8'h18);
        chk1(busy_out, 1'b0);
        put(2, 8'h00);
        put(2, 8'h01);
        chk(nv_control_out, 8'h00);
        put(0, 8'h3C);
        drv(2, 8'h02);
        put(2, 8'h03);
        chk(nv_control_out, 8'h03);
        wait_idle();
        chk(nv_control_out, 8'h02);
        chk(nv_data_out, 8'h00);
        put(0, 8'h3F);
        put(2, 8'h03);
        wait_idle();
        chk(nv_data_out, 8'hC3);
        $display("test start refusals and read done");
        // a second reset with the pointer still aimed at the control register
        @(posedge clk_in);
        srst_in <= 1'b1;
        put(8, 8'h00);
        @(posedge clk_in);
        srst_in <= 1'b0;
        @(negedge clk_in);
        chk(nv_control_out, CTRL_RESET);
        chk(pointer1_high_byte_out, PTR_HIGH_RESET);
        chk(pointer2_high_byte_out, PTR_HIGH_RESET);
        $display("test second reset done");
        end_of_test();
    end
endmodule : eeprom_page_write_control_test
